// ### hw/rtci_pkg.sv
package rtci_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets, as seen on the internal register port
    localparam logic [3:0] INTERRUPT_CONTROL_OFS = 4'he;
    localparam logic [3:0] INTERRUPT_FLAGS_OFS = 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt_control field positions
    localparam int ALARM_A_ENABLE_BIT = 7;
    localparam int ALARM_B_ENABLE_BIT = 6;
    localparam int TEST_MODE_BIT = 4;
    localparam int PERIODIC_SELECT_LSB = 0;
    localparam int PERIODIC_SELECT_W = 3;

    // interrupt_flags field positions
    localparam int CLOCK_OUT_DISABLE_BIT = 6;
    localparam int OSC_HALT_FLAG_BIT = 5;
    localparam int PERIODIC_FLAG_BIT = 2;
    localparam int ALARM_A_FLAG_BIT = 1;
    localparam int ALARM_B_FLAG_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset, and the read value of an unmapped offset
    localparam logic [2:0] PERIODIC_SELECT_RESET = 3'h0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // periodic select codes
    localparam logic [2:0] PSEL_OFF = 3'h0;
    localparam logic [2:0] PSEL_FIXED_LOW = 3'h1;
    localparam logic [2:0] PSEL_PULSE_2HZ = 3'h2;
    localparam logic [2:0] PSEL_PULSE_1HZ = 3'h3;
    localparam logic [2:0] PSEL_EVERY_SECOND = 3'h4;
    localparam logic [2:0] PSEL_EVERY_MINUTE = 3'h5;
    localparam logic [2:0] PSEL_EVERY_HOUR = 3'h6;
    localparam logic [2:0] PSEL_EVERY_MONTH = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // crystal rates and pulse timing, in their own units
    localparam int XTAL_HZ_DEFAULT = 32768;
    localparam int XTAL_HZ_ALT = 32000;
    localparam int PULSE_LAG_US_32K768 = 92;
    localparam int PULSE_LAG_US_32K000 = 94;
    localparam int PULSE_LOW_MS_32K000 = 496;
    localparam int US_PER_S = 1000000;
    localparam int MS_PER_S = 1000;
    localparam int PHASE_W = 17;

    // bcd values that mark the top of a minute, hour and month
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_FIRST_DAY = 8'h01;

endpackage : rtci_pkg

// ### hw/rtci_sync.sv
`timescale 1ns/1ps
module rtci_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import rtci_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // first stage is only ever read by the second stage
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // two-flop synchroniser, resets to constant zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : rtci_sync

// ### hw/rtci_alarm.sv
`timescale 1ns/1ps
module rtci_alarm (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sec_tick,
    input wire logic [2:0] cal_weekday,
    input wire logic [7:0] cal_hour,
    input wire logic [7:0] cal_minute,
    input wire logic [6:0] alarm_weekdays,
    input wire logic [7:0] alarm_hour,
    input wire logic [7:0] alarm_minute,
    input wire logic alarm_enable,
    input wire logic flag_clear,
    output logic alarm_flag
);
    import rtci_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // compare; weekday code 7 maps to a zero pad bit so it never matches
    logic [7:0] day_mask;
    logic match_now;
    logic set_flag;
    logic match_seen_q;
    logic flag_q;
    logic flag_d;

    assign day_mask = {1'b0, alarm_weekdays};
    assign match_now = day_mask[cal_weekday] && (cal_hour == alarm_hour)
                       && (cal_minute == alarm_minute);
    assign set_flag = sec_tick && match_now && !match_seen_q && alarm_enable;
    // set wins over a clear in the same cycle
    assign flag_d = set_flag || (flag_q && !flag_clear);

    ////////////////////////////////////////////////////////////////////////////
    // match history is sampled at counter updates only, so a match that
    // persists for a whole minute sets the flag just once
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_seen_q <= 1'b0;
            flag_q <= FLAG_RESET;
        end else begin
            if (sec_tick) begin
                match_seen_q <= match_now;
            end
            flag_q <= flag_d;
        end
    end

    assign alarm_flag = flag_q;

    ////////////////////////////////////////////////////////////////////////////
    a_alarm_flag_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
        (sec_tick && match_now && !match_seen_q && alarm_enable) |=> flag_q)
        else $error("alarm flag not set on match");
    a_alarm_flag_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
        (flag_q && !flag_clear) |=> flag_q)
        else $error("alarm flag dropped without clear");
    a_alarm_no_enable: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!flag_q && !alarm_enable) |=> !flag_q)
        else $error("alarm flag set while disabled");

endmodule : rtci_alarm

// ### hw/rtci_top.sv
`timescale 1ns/1ps
module rtci_top #(
    parameter int XTAL_HZ = rtci_pkg::XTAL_HZ_DEFAULT
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic xtal_clk,
    input wire logic osc_halt_flag,
    input wire logic sec_tick,
    input wire logic [7:0] cal_second,
    input wire logic [7:0] cal_minute,
    input wire logic [7:0] cal_hour,
    input wire logic [2:0] cal_weekday,
    input wire logic [7:0] cal_day,
    input wire logic [6:0] alarm_a_weekdays,
    input wire logic [7:0] alarm_a_hour,
    input wire logic [7:0] alarm_a_minute,
    input wire logic [6:0] alarm_b_weekdays,
    input wire logic [7:0] alarm_b_hour,
    input wire logic [7:0] alarm_b_minute,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    output logic irq_n,
    output logic irq_n_oe,
    output logic crystal_clock_out,
    output logic crystal_clock_out_oe
);
    import rtci_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pulse timing in crystal cycles, derived from the crystal rate
    localparam int LAG_US = (XTAL_HZ == XTAL_HZ_ALT) ? PULSE_LAG_US_32K000 : PULSE_LAG_US_32K768;
    localparam int LAG_RAW = (LAG_US * XTAL_HZ) / US_PER_S;
    localparam int LAG_CYC = (LAG_RAW < 1) ? 1 : LAG_RAW;
    // 32000 Hz cannot split evenly on the second divider, hence 0.496 s low
    localparam int LOW_CYC = (XTAL_HZ == XTAL_HZ_ALT) ?
                             (PULSE_LOW_MS_32K000 * XTAL_HZ) / MS_PER_S : XTAL_HZ / 2;
    localparam int HIGH_CYC = XTAL_HZ - LOW_CYC;
    localparam logic [PHASE_W-1:0] P_LAG = PHASE_W'(LAG_CYC);
    localparam logic [PHASE_W-1:0] P_HALF_END = PHASE_W'(LAG_CYC + LOW_CYC);
    localparam logic [PHASE_W-1:0] P_Q1_END = PHASE_W'(LAG_CYC + LOW_CYC / 2);
    localparam logic [PHASE_W-1:0] P_Q2_END = PHASE_W'(LAG_CYC + LOW_CYC + HIGH_CYC / 2);
    localparam logic [PHASE_W-1:0] P_MAX = '1;

    // level modes are the codes with the top bit set
    function automatic logic is_level(input logic [2:0] sel);
        return sel[2];
    endfunction : is_level

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic alarm_a_enable_q;
    logic alarm_b_enable_q;
    logic test_mode_q;
    logic [2:0] periodic_select_q;
    logic clock_out_disable_q;
    logic periodic_flag_q;
    logic alarm_a_flag;
    logic alarm_b_flag;
    logic [7:0] reg_rdata_q;
    // output flops
    logic irq_n_q;
    logic irq_n_oe_q;
    logic clk_out_q;
    logic clk_out_oe_q;
    // crystal sampling and phase since last seconds tick
    logic xtal_s;
    logic xtal_prev_q;
    logic [PHASE_W-1:0] phase_q;
    logic [PHASE_W-1:0] phase_d;

    ////////////////////////////////////////////////////////////////////////////
    // register port decode
    logic ctrl_wr;
    logic flags_wr;
    logic periodic_clear;
    logic alarm_a_clear;
    logic alarm_b_clear;
    logic [7:0] control_view;
    logic [7:0] flags_view;
    logic [7:0] read_mux;

    assign ctrl_wr = reg_wr_en && (reg_addr == INTERRUPT_CONTROL_OFS);
    assign flags_wr = reg_wr_en && (reg_addr == INTERRUPT_FLAGS_OFS);
    assign periodic_clear = flags_wr && !reg_wdata[PERIODIC_FLAG_BIT];
    assign alarm_a_clear = flags_wr && !reg_wdata[ALARM_A_FLAG_BIT];
    assign alarm_b_clear = flags_wr && !reg_wdata[ALARM_B_FLAG_BIT];

    assign control_view = {alarm_a_enable_q, alarm_b_enable_q, 1'b0, test_mode_q,
                           1'b0, periodic_select_q};
    assign flags_view = {1'b0, clock_out_disable_q, osc_halt_flag, 2'b00,
                         periodic_flag_q, alarm_a_flag, alarm_b_flag};
    assign read_mux = (reg_addr == INTERRUPT_CONTROL_OFS) ? control_view :
                      (reg_addr == INTERRUPT_FLAGS_OFS) ? flags_view : UNMAPPED_READ;

    ////////////////////////////////////////////////////////////////////////////
    // control writes; the halt flag overrides any write in the same cycle
    // halt forces fields zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_a_enable_q <= ENABLE_RESET;
            alarm_b_enable_q <= ENABLE_RESET;
            test_mode_q <= 1'b0;
            periodic_select_q <= PERIODIC_SELECT_RESET;
            clock_out_disable_q <= 1'b0;
        end else if (osc_halt_flag) begin
            alarm_a_enable_q <= 1'b0;
            alarm_b_enable_q <= 1'b0;
            test_mode_q <= 1'b0;
            periodic_select_q <= PSEL_OFF;
            clock_out_disable_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                alarm_a_enable_q <= reg_wdata[ALARM_A_ENABLE_BIT];
                alarm_b_enable_q <= reg_wdata[ALARM_B_ENABLE_BIT];
                test_mode_q <= reg_wdata[TEST_MODE_BIT];
                periodic_select_q <= reg_wdata[PERIODIC_SELECT_LSB +: PERIODIC_SELECT_W];
            end
            if (flags_wr) begin
                clock_out_disable_q <= reg_wdata[CLOCK_OUT_DISABLE_BIT];
            end
        end
    end

    // read data is registered and held between reads
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= READ_DATA_RESET;
        end else if (reg_rd_en) begin
            reg_rdata_q <= read_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm channels
    // two identical alarm instances
    rtci_alarm u_alarm_a (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sec_tick(sec_tick),
        .cal_weekday(cal_weekday),
        .cal_hour(cal_hour),
        .cal_minute(cal_minute),
        .alarm_weekdays(alarm_a_weekdays),
        .alarm_hour(alarm_a_hour),
        .alarm_minute(alarm_a_minute),
        .alarm_enable(alarm_a_enable_q),
        .flag_clear(alarm_a_clear),
        .alarm_flag(alarm_a_flag)
    );

    rtci_alarm u_alarm_b (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sec_tick(sec_tick),
        .cal_weekday(cal_weekday),
        .cal_hour(cal_hour),
        .cal_minute(cal_minute),
        .alarm_weekdays(alarm_b_weekdays),
        .alarm_hour(alarm_b_hour),
        .alarm_minute(alarm_b_minute),
        .alarm_enable(alarm_b_enable_q),
        .flag_clear(alarm_b_clear),
        .alarm_flag(alarm_b_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // crystal edges seen on the core clock
    rtci_sync #(.WIDTH(1)) u_xtal_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in(xtal_clk),
        .sync_out(xtal_s)
    );

    logic xtal_rise;
    logic [PHASE_W-1:0] phase_inc;
    assign xtal_rise = xtal_s && !xtal_prev_q;
    assign phase_inc = phase_q + PHASE_W'(1);
    // phase restarts on each (trimmed) tick
    assign phase_d = sec_tick ? '0 :
                     (xtal_rise && (phase_q != P_MAX)) ? phase_inc : phase_q;

    // phase counts crystal edges; saturates if the tick ever stops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            xtal_prev_q <= 1'b0;
            phase_q <= '0;
        end else begin
            xtal_prev_q <= xtal_s;
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // periodic waveform
    logic low_1hz;
    logic low_2hz;
    logic ev_minute;
    logic ev_hour;
    logic ev_month;
    logic level_event;
    logic pulse_flag;
    logic periodic_flag_d;

    assign low_1hz = (phase_q >= P_LAG) && (phase_q < P_HALF_END);
    assign low_2hz = ((phase_q >= P_LAG) && (phase_q < P_Q1_END)) ||
                     ((phase_q >= P_HALF_END) && (phase_q < P_Q2_END));

    assign ev_minute = sec_tick && (cal_second == BCD_ZERO);
    assign ev_hour = ev_minute && (cal_minute == BCD_ZERO);
    assign ev_month = ev_hour && (cal_hour == BCD_ZERO) && (cal_day == BCD_FIRST_DAY);
    assign level_event = (periodic_select_q == PSEL_EVERY_SECOND) ? sec_tick :
                         (periodic_select_q == PSEL_EVERY_MINUTE) ? ev_minute :
                         (periodic_select_q == PSEL_EVERY_HOUR) ? ev_hour :
                         (periodic_select_q == PSEL_EVERY_MONTH) ? ev_month : 1'b0;

    assign pulse_flag = (periodic_select_q == PSEL_FIXED_LOW) ? 1'b1 :
                        (periodic_select_q == PSEL_PULSE_2HZ) ? low_2hz :
                        (periodic_select_q == PSEL_PULSE_1HZ) ? low_1hz : 1'b0;
    assign periodic_flag_d = is_level(periodic_select_q) ?
                             (level_event || (periodic_flag_q && !periodic_clear)) : pulse_flag;

    // in pulse modes the flag simply mirrors the waveform
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            periodic_flag_q <= FLAG_RESET;
        end else begin
            periodic_flag_q <= periodic_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers
    logic any_source;
    assign any_source = periodic_flag_q || (alarm_a_flag && alarm_a_enable_q)
                        || (alarm_b_flag && alarm_b_enable_q);

    // open-drain interrupt: enable high while pulling low
    // active source drives pin low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_n_q <= 1'b1;
            irq_n_oe_q <= 1'b0;
        end else begin
            irq_n_q <= !any_source;
            irq_n_oe_q <= any_source;
        end
    end

    // raw crystal, trimming never touches it
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_out_q <= 1'b0;
            clk_out_oe_q <= 1'b1;
        end else begin
            clk_out_q <= xtal_s;
            clk_out_oe_q <= !clock_out_disable_q;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign irq_n = irq_n_q;
    assign irq_n_oe = irq_n_oe_q;
    assign crystal_clock_out = clk_out_q;
    assign crystal_clock_out_oe = clk_out_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_irq_asserts: assert property (@(posedge core_clk) disable iff (!reset_n)
        any_source |=> (!irq_n && irq_n_oe))
        else $error("interrupt pin not pulled low");
    a_irq_releases: assert property (@(posedge core_clk) disable iff (!reset_n)
        !any_source |=> (irq_n && !irq_n_oe))
        else $error("interrupt pin not released");
    a_halt_forces: assert property (@(posedge core_clk) disable iff (!reset_n)
        osc_halt_flag |=> (periodic_select_q == PSEL_OFF && !alarm_a_enable_q
                           && !alarm_b_enable_q && !clock_out_disable_q && !test_mode_q))
        else $error("halt did not clear control fields");
    a_select_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        (periodic_select_q == PSEL_OFF) |=> !periodic_flag_q)
        else $error("periodic flag set with select off");
    a_fixed_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        (periodic_select_q == PSEL_FIXED_LOW) |=> ##1 !irq_n)
        else $error("fixed low code did not hold pin low");
    a_level_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        (is_level(periodic_select_q) && level_event) |=> periodic_flag_q ##1 !irq_n)
        else $error("level event did not assert interrupt");
    a_level_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        (is_level(periodic_select_q) && periodic_clear && !level_event) |=> !periodic_flag_q)
        else $error("periodic flag not cleared");
    a_pulse_lag: assert property (@(posedge core_clk) disable iff (!reset_n)
        (sec_tick && periodic_select_q == PSEL_PULSE_1HZ && !ctrl_wr && !osc_halt_flag)
        |=> !periodic_flag_q)
        else $error("pulse fell without lag");
    a_clkout_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        clock_out_disable_q |=> !crystal_clock_out_oe)
        else $error("clock out driven while disabled");
    a_clkout_raw: assert property (@(posedge core_clk) disable iff (!reset_n)
        ##1 (crystal_clock_out == $past(xtal_s)))
        else $error("clock out does not follow crystal");

endmodule : rtci_top

// ### sim/rtci_host_model.sv
`timescale 1ns/1ps
// crystal source and pulled-up interrupt wire on the host side
module rtci_host_model (
    output logic xtal_clk,
    input wire logic irq_n,
    input wire logic irq_n_oe,
    output logic irq_pin
);
    // free-running crystal, 160 ns period, unrelated to core_clk
    initial begin
        xtal_clk = 1'b0;
        forever #80 xtal_clk = ~xtal_clk;
    end
    // pulled high when undriven; a driven pin shows the data bit, so a stuck-high driver is seen
    assign irq_pin = irq_n_oe ? irq_n : 1'b1;
endmodule : rtci_host_model

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rtci_pkg::*;
    localparam logic [3:0] CR = INTERRUPT_CONTROL_OFS; // control register
    localparam logic [3:0] FR = INTERRUPT_FLAGS_OFS; // flag register
    logic core_clk, reset_n, xtal_clk, halt, tick, wr, rd;
    logic irq_n, irq_oe, pin, ck_out, ck_oe;
    logic [7:0] sec, mnt, hr, day, am, bm, wdata, rdata, got;
    logic [3:0] addr;
    logic [2:0] wday;
    int failures, total_checks, n;
    int cyc = 0;
    // short second (64 crystal edges) keeps pulse modes quick
    rtci_top #(.XTAL_HZ(64)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .xtal_clk(xtal_clk), .osc_halt_flag(halt), .sec_tick(tick),
        .cal_second(sec), .cal_minute(mnt), .cal_hour(hr), .cal_weekday(wday),
        .cal_day(day), .alarm_a_weekdays(7'h04), .alarm_a_hour(8'h12),
        .alarm_a_minute(am), .alarm_b_weekdays(7'h04), .alarm_b_hour(8'h12),
        .alarm_b_minute(bm), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr_en(wr), .reg_rd_en(rd), .reg_rdata(rdata), .irq_n(irq_n),
        .irq_n_oe(irq_oe), .crystal_clock_out(ck_out),
        .crystal_clock_out_oe(ck_oe));
    rtci_host_model i_host (.xtal_clk(xtal_clk), .irq_n(irq_n), .irq_n_oe(irq_oe),
        .irq_pin(pin));
    ////////////////////////////////////////
    // comparisons and bus cycles
    task automatic chk1(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t pin got %b exp %b", $time, g, e);
        end
    endtask : chk1
    task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 got = rdata;
        total_checks++;
        if (got !== e) begin
            failures++;
            $display("[ERR] %0t reg %h got %h exp %h", $time, a, got, e);
        end
    endtask : chk_reg
    // write strobe, then room for the pin to follow
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : wr_reg
    task automatic tick_s;
        @(posedge core_clk);
        tick <= 1'b1;
        @(posedge core_clk);
        tick <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : tick_s
    // edges of the clock output over 20 crystal periods
    task automatic toggles(output int t);
        logic p;
        t = 0;
        p = ck_out;
        repeat (160) begin
            @(posedge core_clk);
            #1 t += (ck_out !== p);
            p = ck_out;
        end
    endtask : toggles
    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    // scenarios
    task automatic t_alarm;
        chk_reg(CR, 8'h00);
        chk1(pin, 1'b1);
        chk1(ck_oe, 1'b1);
        chk_reg(FR, 8'h20);
        halt <= 1'b0;
        tick_s;
        chk_reg(FR, 8'h00);
        mnt <= 8'h29;
        tick_s;
        wr_reg(CR, 8'h80);
        mnt <= 8'h30;
        tick_s;
        chk_reg(FR, 8'h02);
        chk1(pin, 1'b0);
        wr_reg(CR, 8'h81);
        wr_reg(FR, 8'h05);
        chk_reg(FR, 8'h04);
        chk1(pin, 1'b0);
        tick_s;
        chk_reg(FR, 8'h04);
        wr_reg(CR, 8'h00);
        chk1(pin, 1'b1);
        mnt <= 8'h29;
        wr_reg(CR, 8'h40);
        mnt <= 8'h31;
        tick_s;
        chk_reg(FR, 8'h01);
        chk1(pin, 1'b0);
        wr_reg(CR, 8'h00);
        chk1(pin, 1'b1);
        wr_reg(FR, 8'h06);
        chk_reg(FR, 8'h00);
        // wrong weekday: hour and minute agree, yet no flag
        wday <= 3'h3;
        wr_reg(CR, 8'h80);
        mnt <= 8'h30;
        tick_s;
        chk_reg(FR, 8'h00);
        chk1(pin, 1'b1);
        wr_reg(CR, 8'h00);
    endtask : t_alarm
    // every level code fires at midnight on the first day
    task automatic t_level;
        sec <= 8'h00;
        mnt <= 8'h00;
        hr <= 8'h00;
        day <= 8'h01;
        for (int c = 4; c < 8; c++) begin
            wr_reg(CR, 8'(c));
            tick_s;
            chk_reg(FR, 8'h04);
            chk1(pin, 1'b0);
            wr_reg(FR, 8'h03);
            chk1(pin, 1'b1);
        end
        day <= 8'h02;
        tick_s;
        chk_reg(FR, 8'h00);
        // each coarser code must ignore a tick off its boundary
        sec <= 8'h01;
        wr_reg(CR, 8'h05);
        tick_s;
        chk_reg(FR, 8'h00);
        sec <= 8'h00;
        mnt <= 8'h01;
        wr_reg(CR, 8'h06);
        tick_s;
        chk_reg(FR, 8'h00);
        mnt <= 8'h00;
        hr <= 8'h01;
        day <= 8'h01;
        wr_reg(CR, 8'h07);
        tick_s;
        chk_reg(FR, 8'h00);
        chk1(pin, 1'b1);
    endtask : t_level
    // low time and number of falls within one short second
    task automatic t_pulse;
        int lows, falls;
        logic p;
        for (int c = 2; c < 4; c++) begin
            wr_reg(CR, 8'(c));
            tick_s;
            lows = 0;
            falls = 0;
            p = 1'b1;
            repeat (520) begin
                @(posedge core_clk);
                #1 lows += (pin == 1'b0);
                falls += (p && !pin);
                p = pin;
            end
            chk1(lows > 244 && lows < 268, 1'b1);
            chk1(falls == 4 - c, 1'b1);
        end
        wr_reg(CR, 8'h00);
    endtask : t_pulse
    task automatic t_clk_halt;
        toggles(n);
        chk1(n > 38 && n < 42, 1'b1);
        wr_reg(FR, 8'h40);
        chk1(ck_oe, 1'b0);
        wr_reg(FR, 8'h00);
        chk1(ck_oe, 1'b1);
        halt <= 1'b1;
        wr_reg(CR, 8'hd7);
        wr_reg(FR, 8'h40);
        chk_reg(CR, 8'h00);
        chk_reg(FR, 8'h20);
        chk1(ck_oe, 1'b1);
        chk_reg(4'h3, UNMAPPED_READ);
        halt <= 1'b0;
    endtask : t_clk_halt
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // hang guard, far above the roughly 1500 cycles needed
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            complete_run;
        end
    end
    initial begin
        {reset_n, tick, wr, rd, addr, wdata} = '0;
        // power-on with the oscillator-halt flag raised
        halt = 1'b1;
        wday = 3'h2;
        {sec, mnt, hr, day, am, bm} = 48'h15_3012_0530_31;
        failures = 0;
        total_checks = 0;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_alarm;
        t_level;
        t_pulse;
        t_clk_halt;
        complete_run;
    end
endmodule : testbench
